// file: tlc_defs.svh
`ifndef TLC_DEFS_SVH
`define TLC_DEFS_SVH

// ----------------------------------------------------------------------------
// Frame and adaptation timing
// ----------------------------------------------------------------------------
`define TLC_FRAME_BITS      288     // Bits in one transmitted frame
`define TLC_WINDOW_BITS     2       // Leading bits of a frame that allow adaptation
`define TLC_ADAPT_STEPS     8       // Compare-and-adjust operations per frame
`define TLC_STEP_CYCLES     16      // Clock cycles between two adaptations

// ----------------------------------------------------------------------------
// Level thresholds, millivolts of AC peak
// ----------------------------------------------------------------------------
`define TLC_LOW_MV          400     // Below this the gain rises
`define TLC_HIGH_MV         600     // Above this the gain falls
`define TLC_PEAK_W          12      // Width of the peak sample in millivolts

// ----------------------------------------------------------------------------
// Gain setting, 3 dB per step over 0 to 21 dB
// ----------------------------------------------------------------------------
`define TLC_GAIN_LEVELS     8       // Number of gain settings
`define TLC_GAIN_RESET      0       // Gain setting after reset

`endif

// file: tlc_pkg.sv
package tlc_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------

    // Transmitter sequencing state
    typedef enum logic [0:0] {
        TLC_IDLE,
        TLC_SEND
    } tlc_state_t;

    // Digital transmit pins travelling together
    typedef struct packed {
        logic active;   // Transmitter active, enables the line driver
        logic bit_val;  // Unmodulated bit: 0 space, 1 mark
    } tlc_tx_t;

    // Outcome of one peak comparison
    typedef struct packed {
        logic below_low;
        logic above_high;
    } tlc_cmp_t;

endpackage

// file: tlc_peak_cmp.sv
`timescale 1ns/1ns
`default_nettype none
`include "tlc_defs.svh"

module tlc_peak_cmp #(
    parameter int PEAK_W  = `TLC_PEAK_W,
    parameter int LOW_MV  = `TLC_LOW_MV,
    parameter int HIGH_MV = `TLC_HIGH_MV
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    // Peak sample from the level sense path
    input  wire logic [PEAK_W-1:0] peak_mv_in,
    // Registered comparison
    output var  tlc_pkg::tlc_cmp_t cmp_out
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (LOW_MV >= HIGH_MV || HIGH_MV >= (1 << PEAK_W)) begin : g_bad
        $error("tlc_peak_cmp: thresholds do not fit");
    end

    localparam logic [PEAK_W-1:0] LOW_C  = PEAK_W'(LOW_MV);   // Lower threshold
    localparam logic [PEAK_W-1:0] HIGH_C = PEAK_W'(HIGH_MV);  // Upper threshold

    tlc_pkg::tlc_cmp_t cmp_nxt;  // Next comparison

    // ------------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------------

    // Both thresholds strict, the band between them is the dead zone
    always_comb begin
        cmp_nxt.below_low  = (peak_mv_in < LOW_C);
        cmp_nxt.above_high = (peak_mv_in > HIGH_C);
    end

    // Registered so the adjust logic sees a stable answer
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmp_out <= '0;
        end else begin
            cmp_out <= cmp_nxt;
        end
    end

endmodule
`default_nettype wire

// file: tlc_level_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "tlc_defs.svh"

module tlc_level_control #(
    parameter int FRAME_BITS  = `TLC_FRAME_BITS,
    parameter int WINDOW_BITS = `TLC_WINDOW_BITS,
    parameter int ADAPT_STEPS = `TLC_ADAPT_STEPS,
    parameter int STEP_CYCLES = `TLC_STEP_CYCLES,
    parameter int GAIN_LEVELS = `TLC_GAIN_LEVELS,
    parameter int PEAK_W      = `TLC_PEAK_W
) (
    // Clock and reset
    input  wire logic                           clk_in,
    input  wire logic                           srst_in,
    // Transmit request and bit pacing
    input  wire logic                           tx_req_in,
    input  wire logic                           bit_tick_in,
    input  wire logic                           tx_bit_in,
    // Level sense, AC peak in millivolts
    input  wire logic [PEAK_W-1:0]              level_sense_input,
    // Transmit pins and gain setting
    output var  tlc_pkg::tlc_tx_t               tx_out,
    output logic [$clog2(GAIN_LEVELS)-1:0]      gain_out,
    output logic                                adapt_busy_out
);

    // ------------------------------------------------------------------------
    // Parameter check and widths
    // ------------------------------------------------------------------------
    if (FRAME_BITS <= WINDOW_BITS || ADAPT_STEPS < 1 || STEP_CYCLES < 1 ||
        GAIN_LEVELS < 2) begin : g_bad
        $error("tlc_level_control: parameters out of range");
    end

    localparam int BW = $clog2(FRAME_BITS);           // Bit counter width
    localparam int AW = $clog2(ADAPT_STEPS + 1);      // Adaptation counter width
    localparam int SW = $clog2(STEP_CYCLES + 1);      // Step timer width
    localparam int GW = $clog2(GAIN_LEVELS);          // Gain width

    localparam logic [BW-1:0] LAST_BIT = BW'(FRAME_BITS - 1);
    localparam logic [BW-1:0] WIN_END  = BW'(WINDOW_BITS);
    localparam logic [AW-1:0] STEPS_C  = AW'(ADAPT_STEPS);
    localparam logic [SW-1:0] STEP_END = SW'(STEP_CYCLES - 1);
    localparam logic [GW-1:0] GAIN_MAX = GW'(GAIN_LEVELS - 1);
    localparam logic [GW-1:0] GAIN_RST = GW'(`TLC_GAIN_RESET);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    tlc_pkg::tlc_state_t state_r, state_nxt;     // Sequencer
    logic [BW-1:0]       bit_cnt_r, bit_cnt_nxt; // Bit within frame
    logic [AW-1:0]       adapt_cnt_r, adapt_cnt_nxt; // Adaptations done
    logic [SW-1:0]       step_r, step_nxt;       // Spacing timer
    logic [GW-1:0]       gain_r, gain_nxt;       // Gain setting
    tlc_pkg::tlc_tx_t    tx_nxt;                 // Next pin values
    logic                busy_nxt;               // Window still adapting
    tlc_pkg::tlc_cmp_t   cmp;                    // Registered comparison
    logic                window;                 // In the adaptation bits
    logic                adapt_go;               // Adaptation fires now

    // ------------------------------------------------------------------------
    // Peak comparator
    // ------------------------------------------------------------------------
    tlc_peak_cmp #(
        .PEAK_W  (PEAK_W),
        .LOW_MV  (`TLC_LOW_MV),
        .HIGH_MV (`TLC_HIGH_MV)
    ) u_cmp (
        .clk_in     (clk_in),
        .srst_in    (srst_in),
        .peak_mv_in (level_sense_input),
        .cmp_out    (cmp)
    );

    // Adaptation only in the leading bits of a frame, and at most eight times
    assign window   = (state_r == tlc_pkg::TLC_SEND) && (bit_cnt_r < WIN_END);
    assign adapt_go = window && (step_r == STEP_END) && (adapt_cnt_r < STEPS_C);

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------

    // Frame sequencing, adaptation pacing and gain stepping
    always_comb begin
        state_nxt     = state_r;
        bit_cnt_nxt   = bit_cnt_r;
        adapt_cnt_nxt = adapt_cnt_r;
        step_nxt      = step_r;
        gain_nxt      = gain_r;
        tx_nxt        = tx_out;
        case (state_r)
            tlc_pkg::TLC_IDLE: begin
                // A request starts a frame at bit zero
                if (tx_req_in) begin
                    state_nxt     = tlc_pkg::TLC_SEND;
                    bit_cnt_nxt   = '0;
                    adapt_cnt_nxt = '0;
                    step_nxt      = '0;
                    tx_nxt.bit_val = tx_bit_in;
                end
            end
            tlc_pkg::TLC_SEND: begin
                // Bit pacing across a fixed-length frame
                if (bit_tick_in) begin
                    tx_nxt.bit_val = tx_bit_in;
                    if (bit_cnt_r == LAST_BIT) begin
                        bit_cnt_nxt   = '0;
                        adapt_cnt_nxt = '0;
                        step_nxt      = '0;
                        // Request gone: the frame just ended is the last
                        if (!tx_req_in) begin
                            state_nxt = tlc_pkg::TLC_IDLE;
                        end
                    end else begin
                        bit_cnt_nxt = bit_cnt_r + 1'b1;
                    end
                end
                // Spacing timer runs only inside the window
                if (window && !(bit_tick_in && bit_cnt_r == LAST_BIT)) begin
                    step_nxt = (step_r == STEP_END) ? '0 : step_r + 1'b1;
                end
                if (adapt_go) begin
                    adapt_cnt_nxt = adapt_cnt_r + 1'b1;
                    // Saturating steps, a dead band leaves the gain alone
                    if (cmp.below_low && gain_r != GAIN_MAX) begin
                        gain_nxt = gain_r + 1'b1;
                    end else if (cmp.above_high && gain_r != '0) begin
                        gain_nxt = gain_r - 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = tlc_pkg::TLC_IDLE;
            end
        endcase
        tx_nxt.active = (state_nxt == tlc_pkg::TLC_SEND);
        busy_nxt = (state_nxt == tlc_pkg::TLC_SEND) && (bit_cnt_nxt < WIN_END) &&
                   (adapt_cnt_nxt < STEPS_C);
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------

    // Gain survives frames; only reset returns it to the start value
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r        <= tlc_pkg::TLC_IDLE;
            bit_cnt_r      <= '0;
            adapt_cnt_r    <= '0;
            step_r         <= '0;
            gain_r         <= GAIN_RST;
            tx_out         <= '0;
            adapt_busy_out <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            bit_cnt_r      <= bit_cnt_nxt;
            adapt_cnt_r    <= adapt_cnt_nxt;
            step_r         <= step_nxt;
            gain_r         <= gain_nxt;
            tx_out         <= tx_nxt;
            adapt_busy_out <= busy_nxt;
        end
    end

    assign gain_out = gain_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_gain_up;
        @(posedge clk_in) disable iff (srst_in)
        adapt_go && cmp.below_low && gain_r != GAIN_MAX |=> gain_r == $past(gain_r) + 1'b1;
    endproperty
    a_gain_up: assert property (p_gain_up) else $error("gain did not rise on low peak");

    property p_gain_down;
        @(posedge clk_in) disable iff (srst_in)
        adapt_go && cmp.above_high && !cmp.below_low && gain_r != '0 |=> gain_r == $past(gain_r) - 1'b1;
    endproperty
    a_gain_down: assert property (p_gain_down) else $error("gain did not fall on high peak");

    property p_gain_window;
        @(posedge clk_in) disable iff (srst_in)
        !window |=> gain_r == $past(gain_r);
    endproperty
    a_gain_window: assert property (p_gain_window) else $error("gain moved outside window");

    property p_adapt_limit;
        @(posedge clk_in) disable iff (srst_in)
        adapt_cnt_r <= STEPS_C && (adapt_cnt_r != STEPS_C || !adapt_busy_out);
    endproperty
    a_adapt_limit: assert property (p_adapt_limit) else $error("more than eight adaptations");

    property p_frame_wrap;
        @(posedge clk_in) disable iff (srst_in)
        state_r == tlc_pkg::TLC_SEND && bit_tick_in && bit_cnt_r == LAST_BIT
        |=> bit_cnt_r == '0 && adapt_cnt_r == '0;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

    property p_active;
        @(posedge clk_in) disable iff (srst_in)
        tx_out.active == (state_r == tlc_pkg::TLC_SEND);
    endproperty
    a_active: assert property (p_active) else $error("active output disagrees with state");

    property p_bit_follow;
        @(posedge clk_in) disable iff (srst_in)
        state_r == tlc_pkg::TLC_SEND && bit_tick_in |=> tx_out.bit_val == $past(tx_bit_in);
    endproperty
    a_bit_follow: assert property (p_bit_follow) else $error("bit output lost the data");

    property p_saturate;
        @(posedge clk_in) disable iff (srst_in)
        gain_r == GAIN_MAX && !cmp.above_high |=> gain_r == GAIN_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("gain wrapped at maximum");

    property p_no_wrap;
        @(posedge clk_in) disable iff (srst_in)
        gain_r == '0 && adapt_go && cmp.above_high |=> gain_r == '0;
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("gain wrapped at minimum");

    c_raise: cover property (@(posedge clk_in) disable iff (srst_in) adapt_go && cmp.below_low);
    c_lower: cover property (@(posedge clk_in) disable iff (srst_in) adapt_go && cmp.above_high);
    c_eight: cover property (@(posedge clk_in) disable iff (srst_in) adapt_cnt_r == STEPS_C);
    c_wrap:  cover property (@(posedge clk_in) disable iff (srst_in) state_r == tlc_pkg::TLC_SEND
                             && bit_tick_in && bit_cnt_r == LAST_BIT && tx_req_in);

endmodule
`default_nettype wire

// file: tlc_line_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Line driver with output sense, seen as an AC peak in millivolts
// ----------------------------------------------------------------------------
module tlc_line_model (
    // Driver enable and gain from the modem
    input  wire logic        active_in,
    input  wire logic [2:0]  gain_in,
    // Bench-chosen behaviour of the line
    input  wire logic        fixed_in,
    input  wire logic [11:0] fixed_mv_in,
    input  wire logic [11:0] base_mv_in,
    input  wire logic [11:0] step_mv_in,
    // Sensed peak back to the modem
    output logic      [11:0] peak_mv_out
);

    // Peak follows gain unless fixed_in is set; a disabled driver puts no carrier on the line
    always_comb begin
        if (active_in !== 1'b1) begin
            peak_mv_out = 12'h000;        // No carrier, so no AC peak
        end else if (fixed_in) begin
            peak_mv_out = fixed_mv_in;    // Load that ignores the gain
        end else begin
            peak_mv_out = base_mv_in + 12'(gain_in) * step_mv_in;
        end
    end

endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;

    // ------------------------------------------------------------------------
    // Settings: short frame and step keep the run small
    // ------------------------------------------------------------------------
    localparam int STEP  = 4;     // Cycles between adaptations
    localparam int NBITS = 8;     // Bits per frame
    localparam int PER   = 40;    // Bit period, room for all eight steps

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic             clk_in      = 1'b0;
    logic             srst_in     = 1'b1;
    logic             tx_req_in   = 1'b0;
    logic             bit_tick_in = 1'b0;
    logic             tx_bit_in   = 1'b0;
    logic             line_fixed  = 1'b0;   // Line ignores gain when set
    logic [11:0]      fixed_mv    = 12'h000;
    logic [11:0]      sense_mv;             // Peak fed back to the block
    tlc_pkg::tlc_tx_t tx_out;
    logic [2:0]       gain_out;
    logic             busy_out;
    logic [2:0]       mid_gain;             // Gain seen well after the window
    int               error_cnt  = 0;
    int               num_checks = 0;
    int               busy_cyc   = 0;       // Cycles with adaptation pending

    // ------------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------------
    tlc_level_control #(.FRAME_BITS(NBITS), .STEP_CYCLES(STEP)) u_tlc_level_control (
        .clk_in(clk_in), .srst_in(srst_in), .tx_req_in(tx_req_in), .bit_tick_in(bit_tick_in),
        .tx_bit_in(tx_bit_in), .level_sense_input(sense_mv), .tx_out(tx_out),
        .gain_out(gain_out), .adapt_busy_out(busy_out));

    // Closed loop: 100 mV plus 100 mV per gain step
    tlc_line_model u_tlc_line_model (
        .active_in(tx_out.active), .gain_in(gain_out), .fixed_in(line_fixed),
        .fixed_mv_in(fixed_mv), .base_mv_in(12'h064), .step_mv_in(12'h064),
        .peak_mv_out(sense_mv));

    // ------------------------------------------------------------------------
    // Clock and busy-time counter
    // ------------------------------------------------------------------------
    always #20 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (busy_out === 1'b1) begin
            busy_cyc++;
        end
    end

    // ------------------------------------------------------------------------
    // Compare tasks and verdict
    // ------------------------------------------------------------------------
    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_true(input string name, input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %s expected 1 seen %b", name, ok);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // One frame: level setup, bit pacing, bit and gain judgement
    // ------------------------------------------------------------------------
    task automatic send_frame(input int per, input logic fixed, input logic [11:0] mv,
                              input logic [7:0] pat, input logic keep,
                              input logic [2:0] exp_gain, input logic full);
        int k;
        int busy_start;                       // Busy count when the frame began
        busy_start = busy_cyc;
        @(posedge clk_in);
        tx_req_in  <= 1'b1;
        line_fixed <= fixed;
        fixed_mv   <= mv;
        for (k = 0; k < NBITS; k++) begin
            repeat (per - 1) @(posedge clk_in);
            tx_bit_in   <= pat[k];
            bit_tick_in <= 1'b1;
            if (k == NBITS - 1 && !keep) begin
                tx_req_in <= 1'b0;    // Last bit of the final frame
            end
            @(posedge clk_in);
            bit_tick_in <= 1'b0;
            @(negedge clk_in);
            check_val("bit_val", {7'h00, pat[k]}, {7'h00, tx_out.bit_val});
            if (k < NBITS - 1 || keep) begin
                check_val("active", 8'h01, {7'h00, tx_out.active});
            end
            if (k == 2) begin
                mid_gain = gain_out;
            end
        end
        check_val("gain_hold", {5'h00, mid_gain}, {5'h00, gain_out});
        if (full) begin
            check_val("gain", {5'h00, exp_gain}, {5'h00, gain_out});
            check_true("busy_len", (busy_cyc - busy_start) >= 8 * STEP - 1 &&
                       (busy_cyc - busy_start) <= 8 * STEP + 1);
        end else begin
            check_true("short_win", gain_out <= 3'h2 && (busy_cyc - busy_start) < 8 * STEP - 1);
        end
        if (!keep) begin
            @(posedge clk_in);
            @(negedge clk_in);
            check_val("active_end", 8'h00, {7'h00, tx_out.active});
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenario: outputs during reset
    // ------------------------------------------------------------------------
    task automatic reset_values();
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        check_val("rst_tx", 8'h00, {6'h00, tx_out});
        check_val("rst_gain", 8'h00, {5'h00, gain_out});
        check_val("rst_busy", 8'h00, {7'h00, busy_out});
        @(posedge clk_in);
        srst_in <= 1'b0;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios, one task each
    // ------------------------------------------------------------------------

    // Closed loop from minimum gain settles at the first level inside the band
    task automatic scn_closed_loop();
        send_frame(PER, 1'b0, 12'h000, 8'hB4, 1'b0, 3'h3, 1'b1);
    endtask

    // Just under the low threshold: raises until the top setting, then stops
    task automatic scn_raise_sat();
        send_frame(PER, 1'b1, 12'h18F, 8'h4B, 1'b1, 3'h7, 1'b1);
    endtask

    // Exactly on the low threshold: inside the dead band, gain kept
    task automatic scn_low_edge();
        send_frame(PER, 1'b1, 12'h190, 8'hA5, 1'b1, 3'h7, 1'b1);
    endtask

    // Exactly on the high threshold, back-to-back frame start
    task automatic scn_high_edge();
        send_frame(PER, 1'b1, 12'h258, 8'h5A, 1'b1, 3'h7, 1'b1);
    endtask

    // Just over the high threshold: falls to minimum and holds there
    task automatic scn_lower();
        send_frame(PER, 1'b1, 12'h259, 8'hC3, 1'b0, 3'h0, 1'b1);
    endtask

    // Mid band from idle: minimum gain left alone
    task automatic scn_dead_band();
        send_frame(PER, 1'b1, 12'h1F4, 8'h3C, 1'b0, 3'h0, 1'b1);
    endtask

    // Fast bits close the window before all steps fit
    task automatic scn_short_window();
        send_frame(3, 1'b1, 12'h18F, 8'h96, 1'b0, 3'h0, 1'b0);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        reset_values();
        scn_closed_loop();
        scn_raise_sat();
        scn_low_edge();
        scn_high_edge();
        scn_lower();
        scn_dead_band();
        scn_short_window();
        results();
    end

endmodule
`default_nettype wire
